// ===== design/tpc_pkg.sv
// Package for the trigger port controller: command layout, port setup, codes, timing.
// Assumes a single core clock and commands already decoded by the command parser.
package tpc_pkg;

	// Sizes
	localparam int NUM_PORTS = 8;
	localparam int PORT_W    = 3;
	localparam int WAIT_W    = 16;

	// Timing: pause time is counted in microseconds
	localparam int CLK_PERIOD_NS = 20;
	localparam int WAIT_UNIT_NS  = 1000;
	localparam int UNIT_CYC      = (WAIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRE_W         = $clog2(UNIT_CYC);
	localparam logic [PRE_W-1:0] PRE_RELOAD = PRE_W'(UNIT_CYC - 1);

	// Terminal roles, trigger types, polarity and modes
	localparam logic [1:0] TERM_IN   = 2'h1;
	localparam logic [1:0] TERM_OUT  = 2'h2;
	localparam logic [1:0] TYPE_NONE = 2'h0;
	localparam logic [1:0] TYPE_1    = 2'h1;
	localparam logic [1:0] TYPE_2    = 2'h2;
	localparam logic [1:0] TYPE_3    = 2'h3;
	localparam logic       POL_POS   = 1'h1;
	localparam logic       MODE_GATE = 1'h1;
	localparam logic       SWEEP_LAST = 1'h1;

	// Completion output index: type 1 meas done, type 2 step setup, type 3 step meas
	localparam int COMP_MEAS   = 0;
	localparam int COMP_SETUP  = 1;
	localparam int COMP_STEP   = 2;
	localparam int NUM_COMP    = 3;

	typedef enum logic [3:0] {
		op_nop                  = 4'h0,
		port_configure_cmd      = 4'h1,
		port_clear_cmd          = 4'h2,
		sweep_ignore_select_cmd = 4'h3,
		step_setup_out_type_cmd = 4'h4,
		meas_done_out_type_cmd  = 4'h5,
		step_meas_out_type_cmd  = 4'h6,
		trig_mode_cmd           = 4'h7,
		send_trigger_cmd        = 4'h8,
		port_send_trigger_cmd   = 4'h9,
		wait_trigger_cmd        = 4'ha,
		port_wait_trigger_cmd   = 4'hb,
		pause_cmd               = 4'hc,
		port_pause_cmd          = 4'hd
	} tpc_op_type;

	typedef enum logic [2:0] {
		st_idle       = 3'b000,
		st_wait_ext   = 3'b001,
		st_wait_port  = 3'b010,
		st_pause      = 3'b011,
		st_pause_port = 3'b100
	} tpc_state_type;

	typedef struct packed {
		logic              used;
		logic [1:0]        terminal;
		logic              polarity;
		logic [1:0]        ttype;
	} tpc_port_cfg_type;

	typedef struct packed {
		logic              valid;
		tpc_op_type        op;
		logic [PORT_W-1:0] port;
		logic [1:0]        terminal;
		logic              polarity;
		logic [1:0]        ttype;
		logic              mode;
		logic              has_level;
		logic              level;
		logic [NUM_PORTS-1:0] port_mask;
		logic [WAIT_W-1:0] wait_time;
	} tpc_cmd_type;

endpackage

// ===== design/tpc_port_cell.sv
// One trigger port: holds its setup, detects input edges, drives its output.
// Assumes the pin input is synchronous to core_clk.
`timescale 1ns/1ps
module tpc_port_cell (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      cfg_wr,
	input  wire logic                      cfg_clr,
	input  wire tpc_pkg::tpc_port_cfg_type cfg_in,
	input  wire logic                      send_pulse,
	input  wire logic                      send_level_en,
	input  wire logic                      send_level,
	input  wire logic [2:0]                comp_pulse,
	input  wire logic [2:0]                comp_level,
	input  wire logic [2:0]                comp_is_gate,
	input  wire logic                      pin_in,
	output tpc_pkg::tpc_port_cfg_type      cfg,
	output logic                           fire,
	output logic                           pin_out,
	output logic                           pin_oe_n
);
	import tpc_pkg::*;

	tpc_port_cfg_type cfg_reg, cfg_next;
	logic             prev_reg, hold_en_reg, hold_en_next, hold_lvl_reg, hold_lvl_next;
	logic             out_reg, out_next, oe_n_reg, oe_n_next;
	logic             is_out, comp_now;
	logic [1:0]       cidx;

	// Setup, held level and pin drive
	always_comb begin
		cfg_next      = cfg_reg;
		hold_en_next  = hold_en_reg;
		hold_lvl_next = hold_lvl_reg;
		if (cfg_clr) begin
			cfg_next     = '0;
			hold_en_next = 1'b0;
		end else if (cfg_wr) begin
			cfg_next     = cfg_in;
			hold_en_next = 1'b0;
		end else if (send_level_en) begin
			hold_en_next  = 1'b1;
			hold_lvl_next = send_level;
		end else if (send_pulse) begin
			hold_en_next = 1'b0;
		end
		is_out   = cfg_reg.used && (cfg_reg.terminal == TERM_OUT);
		cidx     = cfg_reg.ttype - 2'h1;
		comp_now = (cfg_reg.ttype != TYPE_NONE) &&
			(comp_is_gate[cidx] ? comp_level[cidx] : comp_pulse[cidx]);
		if (!is_out)
			out_next = 1'b0;
		else if (hold_en_next)
			out_next = hold_lvl_next;
		else
			out_next = (send_pulse || comp_now) ? cfg_reg.polarity : ~cfg_reg.polarity;
		oe_n_next = ~is_out;
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_reg      <= '0;
			prev_reg     <= 1'b0;
			hold_en_reg  <= 1'b0;
			hold_lvl_reg <= 1'b0;
			out_reg      <= 1'b0;
			oe_n_reg     <= 1'b1;
		end else begin
			cfg_reg      <= cfg_next;
			prev_reg     <= pin_in;
			hold_en_reg  <= hold_en_next;
			hold_lvl_reg <= hold_lvl_next;
			out_reg      <= out_next;
			oe_n_reg     <= oe_n_next;
		end
	end

	// Input edge toward the active polarity
	assign fire     = cfg_reg.used && (cfg_reg.terminal == TERM_IN) &&
		(pin_in == cfg_reg.polarity) && (prev_reg != cfg_reg.polarity);
	assign cfg      = cfg_reg;
	assign pin_out  = out_reg;
	assign pin_oe_n = oe_n_reg;

endmodule

// ===== design/tpc_trigger_port_controller.sv
// Trigger port controller: executes decoded trigger commands, runs eight ports.
// Assumes one command per cycle offered while cmd_ready is high; all pins synchronous.
//
// What this block does
// - Eight trigger ports, each set up independently for its own purpose.
// - Configure command gives a port role, polarity and optional trigger type.
// - Clear command wipes setup of listed ports; empty list clears all.
// - Sweep-ignore select picks first or last step ignoring step-start input.
// - Step-setup output type command selects edge or gate.
// - Measurement-done output type command selects edge or gate.
// - Step-measurement output type command selects edge or gate.
// - Type 1 triggers act only once external-trigger mode is selected.
// - Send-trigger emits one pulse on the dedicated trigger output.
// - Port send-trigger emits on the given port, using level when given.
// - Wait-trigger stalls until the dedicated input sees a trigger.
// - Port wait-trigger stalls until the given port sees a trigger.
// - Pause holds until time expires, or earlier dedicated trigger in external mode.
// - Port pause holds until time expires, or earlier port trigger in external mode.
// - External mode: trigger ends a pause, or starts a measurement when idle.
`timescale 1ns/1ps
module tpc_trigger_port_controller (
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	input  wire tpc_pkg::tpc_cmd_type    cmd,
	input  wire logic                    ext_trig_in,
	input  wire logic [7:0]              port_in,
	input  wire logic                    step_setup_cond,
	input  wire logic                    meas_cond,
	input  wire logic                    step_meas_cond,
	input  wire logic                    sweep_first_step,
	input  wire logic                    sweep_last_step,
	output logic                         cmd_ready,
	output logic                         cmd_reject,
	output logic                         ext_trig_out,
	output logic [7:0]                   port_out,
	output logic [7:0]                   port_oe_n,
	output logic                         meas_start,
	output logic                         step_start,
	output logic                         sweep_ignore_last,
	output logic                         external_trigger_mode
);
	import tpc_pkg::*;

	tpc_state_type          state_reg, state_next;
	logic [WAIT_W-1:0]      wait_reg, wait_next;
	logic [PRE_W-1:0]       pre_reg, pre_next;
	logic [PORT_W-1:0]      sel_reg, sel_next;
	logic                   mode_reg, mode_next, sweep_reg, sweep_next;
	logic [NUM_COMP-1:0]    gate_reg, gate_next, cond_prev_reg;
	logic                   ext_prev_reg, ready_reg, ready_next, reject_reg, reject_next;
	logic                   trig_out_reg, trig_out_next, meas_reg, meas_next, step_reg, step_next;
	logic [NUM_COMP-1:0]    cond_now, comp_pulse;
	logic                   accept, ext_fire, type1_fire, step_fire, sel_fire, sel_in, end_wait;
	logic [NUM_PORTS-1:0]   fire, cfg_wr, cfg_clr, send_p, send_l, used_vec, t1_in, t2_in, is_in;
	tpc_port_cfg_type [NUM_PORTS-1:0] port_cfg;
	tpc_port_cfg_type       cfg_cmd;

	// Completion conditions and their rising edges
	assign cond_now   = {step_meas_cond, step_setup_cond, meas_cond};
	assign comp_pulse = cond_now & ~cond_prev_reg;
	assign ext_fire   = ext_trig_in && !ext_prev_reg;
	assign accept     = cmd.valid && ready_reg;
	assign cfg_cmd    = '{used: 1'b1, terminal: cmd.terminal, polarity: cmd.polarity, ttype: cmd.ttype};

	// Per-port strobes and classification
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			assign cfg_wr[gi]  = accept && (cmd.op == port_configure_cmd) && (cmd.port == PORT_W'(gi));
			assign cfg_clr[gi] = accept && (cmd.op == port_clear_cmd) &&
				((cmd.port_mask == '0) || cmd.port_mask[gi]);
			assign send_p[gi]  = accept && (cmd.op == port_send_trigger_cmd) && (cmd.port == PORT_W'(gi));
			assign send_l[gi]  = send_p[gi] && cmd.has_level;
			assign used_vec[gi] = port_cfg[gi].used;
			assign is_in[gi]   = port_cfg[gi].used && (port_cfg[gi].terminal == TERM_IN);
			assign t1_in[gi]   = is_in[gi] && (port_cfg[gi].ttype == TYPE_1);
			assign t2_in[gi]   = is_in[gi] && (port_cfg[gi].ttype == TYPE_2);
			tpc_port_cell u_cell (
				.core_clk      (core_clk),
				.sys_rst       (sys_rst),
				.cfg_wr        (cfg_wr[gi]),
				.cfg_clr       (cfg_clr[gi]),
				.cfg_in        (cfg_cmd),
				.send_pulse    (send_p[gi]),
				.send_level_en (send_l[gi]),
				.send_level    (cmd.level),
				.comp_pulse    (comp_pulse),
				.comp_level    (cond_now),
				.comp_is_gate  (gate_reg),
				.pin_in        (port_in[gi]),
				.cfg           (port_cfg[gi]),
				.fire          (fire[gi]),
				.pin_out       (port_out[gi]),
				.pin_oe_n      (port_oe_n[gi])
			);
		end
	endgenerate

	assign type1_fire = |(fire & t1_in);
	assign step_fire  = |(fire & t2_in);
	assign sel_fire   = fire[sel_reg];
	assign sel_in     = is_in[cmd.port];

	// Command execution and stall state
	always_comb begin
		state_next    = state_reg;
		wait_next     = wait_reg;
		pre_next      = pre_reg;
		sel_next      = sel_reg;
		mode_next     = mode_reg;
		sweep_next    = sweep_reg;
		gate_next     = gate_reg;
		reject_next   = 1'b0;
		trig_out_next = 1'b0;
		end_wait      = 1'b0;
		case (state_reg)
			st_idle: begin
				if (accept) begin
					case (cmd.op)
						sweep_ignore_select_cmd: sweep_next = cmd.mode;
						step_setup_out_type_cmd: gate_next[COMP_SETUP] = cmd.mode;
						meas_done_out_type_cmd: gate_next[COMP_MEAS] = cmd.mode;
						step_meas_out_type_cmd: gate_next[COMP_STEP] = cmd.mode;
						trig_mode_cmd: mode_next = cmd.mode;
						send_trigger_cmd: trig_out_next = 1'b1;
						port_send_trigger_cmd: begin
							reject_next = !(port_cfg[cmd.port].used &&
								port_cfg[cmd.port].terminal == TERM_OUT);
						end
						wait_trigger_cmd: state_next = st_wait_ext;
						port_wait_trigger_cmd: begin
							if (sel_in) begin
								state_next = st_wait_port;
								sel_next   = cmd.port;
							end else begin
								reject_next = 1'b1;
							end
						end
						pause_cmd, port_pause_cmd: begin
							state_next = (cmd.op == pause_cmd) ? st_pause : st_pause_port;
							sel_next   = cmd.port;
							wait_next  = cmd.wait_time;
							pre_next   = PRE_RELOAD;
						end
						default: ;
					endcase
				end
			end
			st_wait_ext: end_wait = ext_fire;
			st_wait_port: end_wait = sel_fire;
			st_pause, st_pause_port: begin
				if (mode_reg && ((state_reg == st_pause) ? ext_fire : sel_fire)) begin
					end_wait = 1'b1;
				end else if (wait_reg == '0) begin
					end_wait = 1'b1;
				end else if (pre_reg == '0) begin
					pre_next  = PRE_RELOAD;
					wait_next = wait_reg - WAIT_W'(1);
				end else begin
					pre_next = pre_reg - PRE_W'(1);
				end
			end
			default: state_next = st_idle;
		endcase
		if (end_wait)
			state_next = st_idle;
		ready_next = (state_next == st_idle);
		// Idle trigger in external mode starts a measurement
		meas_next  = mode_reg && (state_reg == st_idle) && (ext_fire || type1_fire);
		step_next  = step_fire && !((sweep_reg == SWEEP_LAST) ? sweep_last_step : sweep_first_step);
	end

	// State registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg     <= st_idle;
			wait_reg      <= '0;
			pre_reg       <= '0;
			sel_reg       <= '0;
			mode_reg      <= 1'b0;
			sweep_reg     <= 1'b0;
			gate_reg      <= '0;
			cond_prev_reg <= '0;
			ext_prev_reg  <= 1'b0;
			ready_reg     <= 1'b1;
			reject_reg    <= 1'b0;
			trig_out_reg  <= 1'b0;
			meas_reg      <= 1'b0;
			step_reg      <= 1'b0;
		end else begin
			state_reg     <= state_next;
			wait_reg      <= wait_next;
			pre_reg       <= pre_next;
			sel_reg       <= sel_next;
			mode_reg      <= mode_next;
			sweep_reg     <= sweep_next;
			gate_reg      <= gate_next;
			cond_prev_reg <= cond_now;
			ext_prev_reg  <= ext_trig_in;
			ready_reg     <= ready_next;
			reject_reg    <= reject_next;
			trig_out_reg  <= trig_out_next;
			meas_reg      <= meas_next;
			step_reg      <= step_next;
		end
	end

	// Outputs straight from registers
	assign cmd_ready             = ready_reg;
	assign cmd_reject            = reject_reg;
	assign ext_trig_out          = trig_out_reg;
	assign meas_start            = meas_reg;
	assign step_start            = step_reg;
	assign sweep_ignore_last     = sweep_reg;
	assign external_trigger_mode = mode_reg;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_cfg_wr;
		accept && cmd.op == port_configure_cmd |=> port_cfg[$past(cmd.port)] == $past(cfg_cmd);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("port setup not stored");

	property p_cfg_other;
		accept && cmd.op == port_configure_cmd && cmd.port != '0 |=> $stable(port_cfg[0]);
	endproperty
	a_cfg_other: assert property (p_cfg_other) else $error("other port setup disturbed");

	property p_clr_all;
		accept && cmd.op == port_clear_cmd && cmd.port_mask == '0 |=> used_vec == '0;
	endproperty
	a_clr_all: assert property (p_clr_all) else $error("clear all left a port");

	property p_sweep;
		accept && cmd.op == sweep_ignore_select_cmd |=> sweep_ignore_last == $past(cmd.mode);
	endproperty
	a_sweep: assert property (p_sweep) else $error("sweep select not taken");

	property p_gate_meas;
		accept && cmd.op == meas_done_out_type_cmd |=> gate_reg[COMP_MEAS] == $past(cmd.mode) ##1
			gate_reg[COMP_MEAS] == $past(gate_reg[COMP_MEAS]);
	endproperty
	a_gate_meas: assert property (p_gate_meas) else $error("meas done type wrong");

	property p_no_ext;
		!external_trigger_mode |=> !meas_start;
	endproperty
	a_no_ext: assert property (p_no_ext) else $error("start without external mode");

	property p_send;
		accept && cmd.op == send_trigger_cmd |=> ext_trig_out ##1
			(ext_trig_out == $past(accept && cmd.op == send_trigger_cmd));
	endproperty
	a_send: assert property (p_send) else $error("send pulse wrong");

	property p_wait_hold;
		state_reg == st_wait_ext && !ext_fire |=> state_reg == st_wait_ext && !cmd_ready;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("wait released early");

	property p_wait_rel;
		state_reg == st_wait_ext && ext_fire |=> cmd_ready ##1 cmd_ready;
	endproperty
	a_wait_rel: assert property (p_wait_rel) else $error("wait not released");

	property p_pause_zero;
		accept && cmd.op == pause_cmd && cmd.wait_time == '0 |=> !cmd_ready ##1 cmd_ready;
	endproperty
	a_pause_zero: assert property (p_pause_zero) else $error("zero pause wrong length");

	property p_ext_start;
		state_reg == st_idle && external_trigger_mode && ext_fire |=> meas_start;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("idle trigger lost");

	// A port wait on a port that is not an input is refused and never stalls
	property p_reject;
		accept && cmd.op == port_wait_trigger_cmd && !sel_in |=> cmd_reject && cmd_ready;
	endproperty
	a_reject: assert property (p_reject) else $error("unsuitable port wait taken");

	property p_port_wait_hold;
		state_reg == st_wait_port && !sel_fire |=> state_reg == st_wait_port && !cmd_ready;
	endproperty
	a_port_wait_hold: assert property (p_port_wait_hold) else $error("port wait released early");

	property p_pause_hold;
		state_reg == st_pause && wait_reg != '0 && !(mode_reg && ext_fire) |=> !cmd_ready;
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("pause released early");

	// The selected ignore step swallows the step start trigger
	property p_step_ignore;
		step_fire && ((sweep_reg == SWEEP_LAST) ? sweep_last_step : sweep_first_step) |=> !step_start;
	endproperty
	a_step_ignore: assert property (p_step_ignore) else $error("ignored step started");

	c_pause_timeout: cover property (state_reg == st_pause && wait_reg == '0 ##1 cmd_ready);
	c_port_wait: cover property (state_reg == st_wait_port && sel_fire ##1 cmd_ready);
	c_port_send: cover property (|send_l ##1 port_oe_n != '1);
	c_ext_meas: cover property (state_reg == st_idle && mode_reg && type1_fire ##1 meas_start);

endmodule

// ===== tb/tb_tpc_trigger_port_controller.sv
// Self-checking bench for the trigger port controller: commands, port pins, completion outputs, stalls.
// Assumes the external equipment model on the trigger lines and a 50 MHz core clock.
`timescale 1ns/1ps
module tb_tpc_trigger_port_controller;
	import tpc_pkg::*;
	logic        core_clk;
	logic        sys_rst;
	tpc_cmd_type cmd;
	logic        ext_trig_in;
	logic [7:0]  port_in;
	logic [2:0]  cond;
	logic        sweep_first_step;
	logic        sweep_last_step;
	logic        cmd_ready;
	logic        cmd_reject;
	logic        ext_trig_out;
	logic [7:0]  port_out;
	logic [7:0]  port_oe_n;
	logic        meas_start;
	logic        step_start;
	logic        sweep_ignore_last;
	logic        external_trigger_mode;
	logic [3:0]  expq[$];
	logic [7:0]  act;
	int          hits[8];
	int          miscompares;
	int          cmp_count;
	int          n;
	int          d;
	tpc_op_type  comp_ops[3] = '{meas_done_out_type_cmd, step_setup_out_type_cmd, step_meas_out_type_cmd};

	tpc_trigger_port_controller tpc_trigger_port_controller_inst (
		.core_clk(core_clk), .sys_rst(sys_rst), .cmd(cmd), .ext_trig_in(ext_trig_in), .port_in(port_in),
		.step_setup_cond(cond[1]), .meas_cond(cond[0]), .step_meas_cond(cond[2]),
		.sweep_first_step(sweep_first_step), .sweep_last_step(sweep_last_step), .cmd_ready(cmd_ready),
		.cmd_reject(cmd_reject), .ext_trig_out(ext_trig_out), .port_out(port_out), .port_oe_n(port_oe_n),
		.meas_start(meas_start), .step_start(step_start), .sweep_ignore_last(sweep_ignore_last),
		.external_trigger_mode(external_trigger_mode));

	tpc_ext_equip tpc_ext_equip_inst (
		.core_clk(core_clk), .ext_trig_out(ext_trig_out), .port_out(port_out), .port_oe_n(port_oe_n),
		.ext_trig_in(ext_trig_in), .port_in(port_in));

	// 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#2;
	endtask

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_ev(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t event: got %b expected %b", $time, got, exp);
		end
	endtask

	// Event monitor: every pulse takes the oldest note; a pulse with no note is a mismatch
	always @(negedge core_clk) begin
		if (sys_rst === 1'b0 && {cmd_reject, ext_trig_out, meas_start, step_start} !== 4'h0) begin
			if (expq.size() == 0)
				check_ev({cmd_reject, ext_trig_out, meas_start, step_start}, 4'h0);
			else
				check_ev({cmd_reject, ext_trig_out, meas_start, step_start}, expq.pop_front());
		end
		for (int i = 0; i < 8; i++)
			if (port_out[i] === act[i])
				hits[i]++;
	end

	// Offer one command for k cycles, then leave the bus idle for one cycle
	task automatic run_cmd(input tpc_op_type op, input int p, input logic [1:0] tm, input logic pl,
		input logic [1:0] ty, input logic md, input logic [7:0] mk, input logic [15:0] wt, input logic hl, input int k);
		cmd = '{1'b1, op, p[2:0], tm, pl, ty, md, hl, 1'b0, mk, wt};
		tick(k);
		cmd.valid = 1'b0;
		tick(1);
	endtask

	task automatic cfg(input int p, input logic [1:0] tm, input logic pl, input logic [1:0] ty);
		run_cmd(port_configure_cmd, p, tm, pl, ty, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
	endtask

	task automatic mcmd(input tpc_op_type op, input logic md);
		run_cmd(op, 0, 2'h0, 1'b0, 2'h0, md, 8'h00, 16'h0000, 1'b0, 1);
	endtask

	task automatic wait_ready(input int k);
		n = 0;
		while (cmd_ready !== 1'b1 && n < k) begin
			tick(1);
			n++;
		end
	endtask

	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask

	task automatic print_verdict();
		$display("Counts: %0d comparisons, %0d mismatches", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 400 cycles
	initial begin
		#200000;
		miscompares++;
		$display("ERROR %0t watchdog expired", $time);
		print_verdict();
	end

	initial begin
		sys_rst = 1'b1;
		cmd = '0;
		cond = 3'h0;
		sweep_first_step = 1'b0;
		sweep_last_step = 1'b0;
		act = 8'h00;
		miscompares = 0;
		cmp_count = 0;
		void'($urandom(32'hd268));
		tick(4);
		sys_rst = 1'b0;
		check_val({cmd_ready, port_oe_n, external_trigger_mode, sweep_ignore_last}, 16'h07fc, "reset");
		done("reset");
		// Back-to-back triggers on the dedicated output
		expq.push_back(4'h4);
		expq.push_back(4'h4);
		run_cmd(send_trigger_cmd, 0, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 2);
		tick(2);
		check_val(16'(tpc_ext_equip_inst.trig_seen), 16'h0002, "sent triggers");
		done("send");
		// Completion outputs in edge then gate behaviour, one port per type
		act[3:1] = 3'h7;
		for (int t = 1; t <= 3; t++) begin
			cfg(t, TERM_OUT, POL_POS, 2'(t));
			check_val({port_oe_n[t], port_out[t]}, 16'h0000, "output idle");
			for (int g = 0; g <= 1; g++) begin
				mcmd(comp_ops[t-1], g[0]);
				hits[t] = 0;
				cond[t-1] = 1'b1;
				tick(5);
				cond[t-1] = 1'b0;
				tick(4);
				check_val(16'(hits[t]), (g == 1) ? 16'h0005 : 16'h0001, "completion width");
			end
		end
		// All three outputs now in gate behaviour: they follow random condition levels
		cond = 3'($urandom);
		tick(2);
		check_val(port_out[3:1], cond, "gate follow");
		cond = 3'h0;
		tick(2);
		done("completion");
		// Port send on an active-low output, plain pulse then held level
		cfg(4, TERM_OUT, 1'b0, TYPE_NONE);
		check_val(port_out[4], 1'b1, "idle level");
		hits[4] = 0;
		run_cmd(port_send_trigger_cmd, 4, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
		tick(3);
		check_val(16'(hits[4]), 16'h0001, "port pulse");
		hits[4] = 0;
		run_cmd(port_send_trigger_cmd, 4, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b1, 1);
		tick(4);
		check_val(16'(hits[4]), 16'h0005, "held level");
		done("port send");
		// Stall on the dedicated input, then on port 6, until the equipment triggers
		d = $urandom_range(12, 3);
		run_cmd(wait_trigger_cmd, 0, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
		tick(d);
		check_val(cmd_ready, 1'b0, "stalled");
		tpc_ext_equip_inst.ext_pulse();
		wait_ready(4);
		check_val(cmd_ready, 1'b1, "released");
		cfg(6, TERM_IN, POL_POS, TYPE_NONE);
		run_cmd(port_wait_trigger_cmd, 6, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
		tick(d);
		check_val(cmd_ready, 1'b0, "port stalled");
		tpc_ext_equip_inst.port_pulse(6, 1'b1);
		wait_ready(4);
		check_val(cmd_ready, 1'b1, "port released");
		// Port send on an input and port wait on an output are refused
		expq.push_back(4'h8);
		run_cmd(port_send_trigger_cmd, 6, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
		expq.push_back(4'h8);
		run_cmd(port_wait_trigger_cmd, 4, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
		tick(2);
		done("waits");
		// Step start suppressed on the selected sweep step only
		cfg(5, TERM_IN, POL_POS, TYPE_2);
		for (int k = 0; k < 4; k++) begin
			mcmd(sweep_ignore_select_cmd, k[1]);
			check_val(sweep_ignore_last, k[1], "ignore select");
			sweep_last_step = k[0];
			sweep_first_step = ~k[0];
			if (k[1] != k[0])
				expq.push_back(4'h1);
			tpc_ext_equip_inst.port_pulse(5, 1'b1);
			tick(3);
		end
		done("sweep");
		// Type 1 and dedicated triggers start a measurement only in external mode
		cfg(7, TERM_IN, POL_POS, TYPE_1);
		tpc_ext_equip_inst.ext_pulse();
		tpc_ext_equip_inst.port_pulse(7, 1'b1);
		tick(3);
		mcmd(trig_mode_cmd, 1'b1);
		check_val(external_trigger_mode, 1'b1, "external mode");
		expq.push_back(4'h2);
		tpc_ext_equip_inst.ext_pulse();
		tick(3);
		expq.push_back(4'h2);
		tpc_ext_equip_inst.port_pulse(7, 1'b1);
		tick(3);
		done("external mode");
		// Pause by time, then pauses cut short by triggers without starting a measurement
		run_cmd(pause_cmd, 0, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0002, 1'b0, 1);
		wait_ready(150);
		check_val(16'(n >= 96 && n <= 104), 16'h0001, "pause length");
		run_cmd(pause_cmd, 0, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0064, 1'b0, 1);
		tick(d);
		tpc_ext_equip_inst.ext_pulse();
		wait_ready(4);
		check_val(cmd_ready, 1'b1, "pause cut");
		run_cmd(port_pause_cmd, 6, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0064, 1'b0, 1);
		tick(d);
		tpc_ext_equip_inst.port_pulse(6, 1'b1);
		wait_ready(4);
		check_val(cmd_ready, 1'b1, "port pause cut");
		mcmd(trig_mode_cmd, 1'b0);
		run_cmd(port_pause_cmd, 6, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0001, 1'b0, 1);
		tick(5);
		tpc_ext_equip_inst.port_pulse(6, 1'b1);
		wait_ready(80);
		check_val(16'(n > 30), 16'h0001, "pause not cut");
		run_cmd(pause_cmd, 0, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
		check_val(cmd_ready, 1'b1, "zero pause");
		done("pause");
		// Clear one listed port, then all ports with an empty list
		run_cmd(port_clear_cmd, 0, 2'h0, 1'b0, 2'h0, 1'b0, 8'h10, 16'h0000, 1'b0, 1);
		check_val(port_oe_n, 8'hf1, "clear listed");
		run_cmd(port_clear_cmd, 0, 2'h0, 1'b0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1);
		check_val(port_oe_n, 8'hff, "clear all");
		check_val(16'(expq.size()), 16'h0000, "events left");
		done("clear");
		print_verdict();
	end
endmodule

// ===== tb/tpc_ext_equip.sv
// External equipment model on the trigger lines: it sends triggers and counts the device's dedicated-output triggers.
// Assumes the lines are synchronous to core_clk and that the bench calls its tasks just after a clock edge.
`timescale 1ns/1ps
module tpc_ext_equip (
	input  wire logic       core_clk,
	input  wire logic       ext_trig_out,
	input  wire logic [7:0] port_out,
	input  wire logic [7:0] port_oe_n,
	output logic            ext_trig_in,
	output logic [7:0]      port_in
);
	logic [7:0] drv;
	int         trig_seen;

	// A pin driven by the device reads back its own level; other pins carry this model's drive
	assign port_in = (port_oe_n & drv) | (~port_oe_n & port_out);

	initial begin
		ext_trig_in = 1'b0;
		drv         = 8'h00;
		trig_seen   = 0;
	end

	// Count the cycles in which the device sends a trigger on the dedicated output
	always @(posedge core_clk) begin
		if (ext_trig_out === 1'b1)
			trig_seen++;
	end

	// Dedicated trigger: a rising edge held for two cycles, then back to idle
	task automatic ext_pulse();
		ext_trig_in = 1'b1;
		repeat (2) @(posedge core_clk);
		#2 ext_trig_in = 1'b0;
	endtask

	// Port trigger: active level v held for two cycles on port p, then inactive
	task automatic port_pulse(input int p, input logic v);
		drv[p] = v;
		repeat (2) @(posedge core_clk);
		#2 drv[p] = ~v;
	endtask
endmodule
